// *** design/slcr_cycle_timer.v ***
// Purpose: Cycle timer offset counter with selectable rollover source.
// Assumes: Advances on each cycle clock enable pulse.
// Notes:   Rollover pulse lasts one core clock.
`timescale 1ns/1ns
`default_nettype none
`include "slcr_defines.vh"
module slcr_cycle_timer (
  // Clock and reset
  input  wire        core_clk,
  input  wire        nrst,
  // Control
  input  wire        enable,
  input  wire        ext_source,
  input  wire        ext_tick,
  input  wire        cyc_tick,
  input  wire        sync_load,
  // Status
  output reg  [11:0] offset_q,
  output reg         rollover_q
);
  wire internal_roll;
  assign internal_roll = cyc_tick && (offset_q == `SLCR_ROLL_CYCLES - 12'h001);
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      offset_q   <= 12'h000;
      rollover_q <= 1'b0;
    end else begin
      rollover_q <= 1'b0;
      if (sync_load) begin
        offset_q <= 12'h000;
      end else if (enable) begin
        if (ext_source ? ext_tick : internal_roll) begin
          offset_q   <= 12'h000;
          rollover_q <= 1'b1;
        end else if (cyc_tick) begin
          offset_q <= offset_q + 12'h001;
        end
      end
    end
  end
endmodule // slcr_cycle_timer
`default_nettype wire

// *** design/slcr_defines.vh ***
// Purpose: Constants for the serial bus link control register bank.
// Assumes: 32-bit register port, byte addresses.
// Notes:   Timing counts derive from the cycle clock rate.
`ifndef SLCR_DEFINES_VH
`define SLCR_DEFINES_VH
`define SLCR_OFF_FAIRNESS   8'hDC
`define SLCR_OFF_LINK_SET   8'hE0
`define SLCR_OFF_LINK_CLR   8'hE4
`define SLCR_OFF_CYC_CNT    8'hF0
`define SLCR_OFF_STATUS     8'hF4
`define SLCR_OFF_ISO_MATCH  8'hF8
`define SLCR_BIT_SOURCE     22
`define SLCR_BIT_MASTER     21
`define SLCR_BIT_ENABLE     20
`define SLCR_BIT_PHY_PKT    10
`define SLCR_BIT_SELF_ID    9
`define SLCR_BIT_LOCK       6
`define SLCR_BIT_TAG_SYNC   6
`define SLCR_LINK_MASK      32'h0070_0640
`define SLCR_FAIR_RESET     8'h00
`define SLCR_ROLL_CYCLES    12'hC00
`define SLCR_ISO_CTX        4
`endif

// *** design/slcr_fair_limiter.v ***
// Purpose: Counts priority arbitration requests per fairness interval.
// Assumes: Interval start is a one-cycle pulse.
// Notes:   A limit of zero allows no priority requests.
`timescale 1ns/1ns
`default_nettype none
module slcr_fair_limiter (
  // Clock and reset
  input  wire       core_clk,
  input  wire       nrst,
  // Control
  input  wire [7:0] limit,
  input  wire       interval_start,
  input  wire       pri_req,
  // Status
  output wire       pri_allow,
  output reg  [7:0] used_q
);
  assign pri_allow = (used_q < limit);
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      used_q <= 8'h00;
    end else if (interval_start) begin
      used_q <= 8'h00;
    end else if (pri_req && pri_allow) begin
      used_q <= used_q + 8'h01;
    end
  end
endmodule // slcr_fair_limiter
`default_nettype wire

// *** design/slcr_link_regs.v ***
// Operation
// - Cap priority requests per fairness interval.
// - Reserved bits read as zero.
// - Set address sets, clear address clears all but lock.
// - Rollover from external input or 3072 cycles.
// - Cycle master sends cycle start each rollover.
// - Non-master accepts received cycle starts.
// - Overrun clears master, blocks setting it.
// - Timer enable gates offset counting.
// - PHY packets to request context if enabled.
// - Self-ID bit admits self-ID packets.
// - Lock forces tag sync filter bits high.
// - Lock bit cleared only by global reset.
//
// Purpose: Link control and fairness registers of a serial bus link.
// Assumes: Register port with read data one cycle after the strobe.
// Notes:   Lock bit is reset only by global_reset_n.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "slcr_defines.vh"
module slcr_link_regs (
  // Clock and resets
  input  wire        core_clk,
  input  wire        nrst,
  input  wire        global_reset_n,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata_q,
  // Cycle timing
  input  wire        cyc_tick,
  input  wire        external_cycle_input,
  input  wire        cycle_overrun_event,
  input  wire        cycle_start_rx,
  output reg         cycle_start_tx_q,
  output reg         cycle_sync_q,
  // Arbitration
  input  wire        fair_interval_start,
  input  wire        pri_req,
  output reg         pri_grant_q,
  // Receiver
  input  wire        ar_req_ctx_enabled,
  input  wire        phy_pkt_rx,
  input  wire        self_id_rx,
  output reg         phy_pkt_accept_q,
  output reg         self_id_accept_q,
  output reg  [3:0]  tag_sync_filter_q
);
  reg  [7:0] fair_limit_q;
  reg        cycle_rollover_source_q;
  reg        cycle_master_role_q;
  reg        cycle_counter_enable_q;
  reg        accept_phy_packets_q;
  reg        accept_self_id_packets_q;
  reg        tag_filter_force_lock_q;
  reg  [3:0] tag_sync_raw_q;
  wire [11:0] cyc_offset;
  wire        rollover;
  wire        pri_allow;
  wire [7:0]  pri_used;
  wire        wr_set;
  wire        wr_clr;
  wire [31:0] link_word;

  // Returns true when the address equals the given offset.
  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  assign wr_set = reg_wr && hit(reg_addr, `SLCR_OFF_LINK_SET);
  assign wr_clr = reg_wr && hit(reg_addr, `SLCR_OFF_LINK_CLR);

  assign link_word = {9'h000, cycle_rollover_source_q, cycle_master_role_q,
                      cycle_counter_enable_q, 9'h000, accept_phy_packets_q,
                      accept_self_id_packets_q, 2'h0, tag_filter_force_lock_q,
                      6'h00};

  slcr_cycle_timer u_timer (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .enable     (cycle_counter_enable_q),
    .ext_source (cycle_rollover_source_q),
    .ext_tick   (external_cycle_input),
    .cyc_tick   (cyc_tick),
    .sync_load  (cycle_start_rx && !cycle_master_role_q),
    .offset_q   (cyc_offset),
    .rollover_q (rollover)
  );

  slcr_fair_limiter u_fair (
    .core_clk       (core_clk),
    .nrst           (nrst),
    .limit          (fair_limit_q),
    .interval_start (fair_interval_start),
    .pri_req        (pri_req),
    .pri_allow      (pri_allow),
    .used_q         (pri_used)
  );

  // Fairness register and set/clear control bits.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fair_limit_q             <= `SLCR_FAIR_RESET;
      cycle_rollover_source_q  <= 1'b0;
      cycle_master_role_q      <= 1'b0;
      cycle_counter_enable_q   <= 1'b0;
      accept_phy_packets_q     <= 1'b0;
      accept_self_id_packets_q <= 1'b0;
      tag_sync_raw_q           <= 4'h0;
    end else begin
      if (reg_wr && hit(reg_addr, `SLCR_OFF_FAIRNESS)) begin
        fair_limit_q <= reg_wdata[7:0];
      end
      if (wr_set) begin
        cycle_rollover_source_q  <= cycle_rollover_source_q | reg_wdata[`SLCR_BIT_SOURCE];
        cycle_counter_enable_q   <= cycle_counter_enable_q | reg_wdata[`SLCR_BIT_ENABLE];
        accept_phy_packets_q     <= accept_phy_packets_q | reg_wdata[`SLCR_BIT_PHY_PKT];
        accept_self_id_packets_q <= accept_self_id_packets_q | reg_wdata[`SLCR_BIT_SELF_ID];
      end else if (wr_clr) begin
        cycle_rollover_source_q  <= cycle_rollover_source_q & ~reg_wdata[`SLCR_BIT_SOURCE];
        cycle_counter_enable_q   <= cycle_counter_enable_q & ~reg_wdata[`SLCR_BIT_ENABLE];
        accept_phy_packets_q     <= accept_phy_packets_q & ~reg_wdata[`SLCR_BIT_PHY_PKT];
        accept_self_id_packets_q <= accept_self_id_packets_q & ~reg_wdata[`SLCR_BIT_SELF_ID];
      end
      if (cycle_overrun_event) begin
        cycle_master_role_q <= 1'b0;
      end else if (wr_set && reg_wdata[`SLCR_BIT_MASTER]) begin
        cycle_master_role_q <= 1'b1;
      end else if (wr_clr && reg_wdata[`SLCR_BIT_MASTER]) begin
        cycle_master_role_q <= 1'b0;
      end
      if (reg_wr && hit(reg_addr, `SLCR_OFF_ISO_MATCH)) begin
        tag_sync_raw_q <= reg_wdata[`SLCR_ISO_CTX-1:0];
      end
    end
  end

  // Lock bit: set only by software, cleared only by the global reset.
  always @(posedge core_clk or negedge global_reset_n) begin
    if (!global_reset_n) begin
      tag_filter_force_lock_q <= 1'b0;
    end else if (wr_set && reg_wdata[`SLCR_BIT_LOCK]) begin
      tag_filter_force_lock_q <= 1'b1;
    end
  end

  // Registered outputs toward link logic.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cycle_start_tx_q  <= 1'b0;
      cycle_sync_q      <= 1'b0;
      pri_grant_q       <= 1'b0;
      phy_pkt_accept_q  <= 1'b0;
      self_id_accept_q  <= 1'b0;
      tag_sync_filter_q <= 4'h0;
    end else begin
      cycle_start_tx_q  <= rollover && cycle_master_role_q;
      cycle_sync_q      <= cycle_start_rx && !cycle_master_role_q;
      pri_grant_q       <= pri_req && pri_allow;
      phy_pkt_accept_q  <= phy_pkt_rx && accept_phy_packets_q && ar_req_ctx_enabled;
      self_id_accept_q  <= self_id_rx && accept_self_id_packets_q;
      tag_sync_filter_q <= tag_sync_raw_q | {`SLCR_ISO_CTX{tag_filter_force_lock_q}};
    end
  end

  // Read data, one cycle after the read strobe.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `SLCR_OFF_FAIRNESS:  reg_rdata_q <= {24'h000000, fair_limit_q};
        `SLCR_OFF_LINK_SET:  reg_rdata_q <= link_word;
        `SLCR_OFF_LINK_CLR:  reg_rdata_q <= link_word;
        `SLCR_OFF_CYC_CNT:   reg_rdata_q <= {20'h00000, cyc_offset};
        `SLCR_OFF_STATUS:    reg_rdata_q <= {24'h000000, pri_used};
        `SLCR_OFF_ISO_MATCH: reg_rdata_q <= {28'h0000000, tag_sync_filter_q};
        default:             reg_rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_q <= 32'h0000_0000;
    end
  end
endmodule // slcr_link_regs
`default_nettype wire

// *** testbench/slcr_checker.sv ***
// Purpose: Port assertions for the link control bank.
// Assumes: Bound to slcr_link_regs.
// Notes:   The fairness limit is tracked from bus writes.
`timescale 1ns/1ns
`default_nettype none
`include "slcr_defines.vh"
module slcr_checker (
  // Clock, reset and bus
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata_q,
  // Link side
  input wire logic        cycle_start_rx,
  input wire logic        cycle_start_tx_q,
  input wire logic        cycle_sync_q,
  input wire logic        fair_interval_start,
  input wire logic        pri_req,
  input wire logic        pri_grant_q,
  input wire logic        ar_req_ctx_enabled,
  input wire logic        phy_pkt_rx,
  input wire logic        self_id_rx,
  input wire logic        phy_pkt_accept_q,
  input wire logic        self_id_accept_q,
  input wire logic [3:0]  tag_sync_filter_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [7:0] lim_q;
  logic [7:0] cnt_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lim_q <= 8'h00;
      cnt_q <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == `SLCR_OFF_FAIRNESS) lim_q <= reg_wdata[7:0];
      cnt_q <= fair_interval_start ? 8'h00 : cnt_q + {7'h00, pri_grant_q};
    end
  end
  property p_fair_rsvd;
    $past(reg_rd) && $past(reg_addr) == 8'hDC |-> reg_rdata_q[31:8] == 24'h000000;
  endproperty
  a_fair_rsvd: assert property (p_fair_rsvd) else $error("fairness reserved bits set");
  property p_link_rsvd;
    $past(reg_rd) && $past(reg_addr) inside {8'hE0, 8'hE4}
      |-> (reg_rdata_q & ~`SLCR_LINK_MASK) == 32'h00000000;
  endproperty
  a_link_rsvd: assert property (p_link_rsvd) else $error("link reserved bits set");
  property p_grant_cap;
    pri_grant_q |-> cnt_q < lim_q;
  endproperty
  a_grant_cap: assert property (p_grant_cap) else $error("grant over limit");
  property p_grant_cause;
    pri_grant_q |-> $past(pri_req);
  endproperty
  a_grant_cause: assert property (p_grant_cause) else $error("grant without request");
  property p_sync_cause;
    cycle_sync_q |-> $past(cycle_start_rx) && !cycle_start_tx_q;
  endproperty
  a_sync_cause: assert property (p_sync_cause) else $error("bad sync pulse");
  property p_tx_single;
    cycle_start_tx_q |=> !cycle_start_tx_q [*3];
  endproperty
  a_tx_single: assert property (p_tx_single) else $error("cycle start too long");
  property p_phy_acc;
    phy_pkt_accept_q |-> $past(phy_pkt_rx) && $past(ar_req_ctx_enabled);
  endproperty
  a_phy_acc: assert property (p_phy_acc) else $error("phy packet wrongly taken");
  property p_sid_acc;
    self_id_accept_q |-> $past(self_id_rx);
  endproperty
  a_sid_acc: assert property (p_sid_acc) else $error("self id wrongly taken");
  property p_lock_force;
    $past(reg_rd) && $past(reg_addr) == 8'hE0 && reg_rdata_q[6] |-> tag_sync_filter_q == 4'hF;
  endproperty
  a_lock_force: assert property (p_lock_force) else $error("filter not forced");
endmodule // slcr_checker
bind slcr_link_regs slcr_checker chk_u (.*);
`default_nettype wire

// *** testbench/slcr_phy_model.sv ***
// Purpose: Physical layer stand-in: cycle clock enable and priority requests.
// Assumes: Cycle enable every 4 core cycles.
// Notes:   Requests pulse every other cycle while burst is high.
`timescale 1ns/1ns
`default_nettype none
module slcr_phy_model (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // Bench control
  input  wire logic burst,
  // Link side
  output var  logic cyc_tick,
  output var  logic pri_req
);
  logic [1:0] div_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_q    <= 2'h0;
      cyc_tick <= 1'b0;
      pri_req  <= 1'b0;
    end else begin
      div_q    <= div_q + 2'h1;
      cyc_tick <= (div_q == 2'h3);
      pri_req  <= burst && !pri_req;
    end
  end
endmodule // slcr_phy_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// Purpose: Self-checking bench for the link control bank.
// Assumes: Physical layer model supplies ticks and requests.
// Notes:   Reads are scored from a queue of expected words.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic core_clk, nrst, global_reset_n, reg_wr, reg_rd, rd_d, burst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata_q;
  logic cyc_tick, external_cycle_input, cycle_overrun_event, cycle_start_rx;
  logic cycle_start_tx_q, cycle_sync_q, fair_interval_start, pri_req, pri_grant_q;
  logic ar_req_ctx_enabled, phy_pkt_rx, self_id_rx, phy_pkt_accept_q, self_id_accept_q;
  logic [3:0]  tag_sync_filter_q;
  logic [31:0] exp_q[$];
  int          error_cnt, checked, n, c;
  slcr_link_regs dut_u (.*);
  slcr_phy_model phy_u (.*);
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= w;
    reg_rd    <= !w;
    if (!w) exp_q.push_back(d);
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic pulse(input logic [4:0] m);
    {fair_interval_start, external_cycle_input, cycle_start_rx, phy_pkt_rx, self_id_rx} <= m;
    @(posedge core_clk);
    {fair_interval_start, external_cycle_input, cycle_start_rx, phy_pkt_rx, self_id_rx} <= 5'h00;
  endtask
  task automatic cmp_evt(input logic [3:0] exp);
    @(negedge core_clk);
    checked++;
    if ({cycle_start_tx_q, cycle_sync_q, phy_pkt_accept_q, self_id_accept_q} !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t events %b exp %b", $time,
               {cycle_start_tx_q, cycle_sync_q, phy_pkt_accept_q, self_id_accept_q}, exp);
    end
    @(posedge core_clk);
  endtask
  task automatic wait_tx(input int lim);
    c = 0;
    do begin
      @(negedge core_clk);
      c++;
    end while (cycle_start_tx_q !== 1'b1 && c < lim);
    @(posedge core_clk);
  endtask
  task automatic report_and_stop;
    $display("error_cnt=%0d checked=%0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge core_clk) rd_d <= reg_rd;
  always @(negedge core_clk) begin
    if (rd_d === 1'b1) cmp(reg_rdata_q, exp_q.pop_front());
  end
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #1000000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    {nrst, global_reset_n, reg_wr, reg_rd, burst, external_cycle_input} <= 6'h00;
    {cycle_overrun_event, cycle_start_rx, fair_interval_start, phy_pkt_rx} <= 4'h0;
    {ar_req_ctx_enabled, self_id_rx, reg_addr, reg_wdata} <= 42'h0;
    n = $urandom(18586);
    repeat (10) @(posedge core_clk);
    nrst           <= 1'b1;
    global_reset_n <= 1'b1;
    @(posedge core_clk);
    acc(0, 8'hDC, 32'h00000000);
    acc(0, 8'h10, 32'h00000000);
    acc(1, 8'hDC, 32'hFFFFFFFF);
    acc(0, 8'hDC, 32'h000000FF);
    acc(1, 8'hE0, 32'hFFFFFFFF);
    acc(0, 8'hE0, 32'h00700640);
    acc(1, 8'hE4, 32'hFFFFFFFF);
    acc(0, 8'hE4, 32'h00000040);
    cmp({28'h0, tag_sync_filter_q}, 32'h0000000F);
    acc(1, 8'hF8, 32'h00000005);
    acc(0, 8'hF8, 32'h0000000F);
    cycle_overrun_event <= 1'b1;
    acc(1, 8'hE0, 32'h00200000);
    acc(0, 8'hE0, 32'h00000040);
    cycle_overrun_event <= 1'b0;
    acc(1, 8'hE0, 32'h00200000);
    acc(0, 8'hE0, 32'h00200040);
    cycle_overrun_event <= 1'b1;
    @(posedge core_clk);
    acc(0, 8'hE0, 32'h00000040);
    cycle_overrun_event <= 1'b0;
    global_reset_n <= 1'b0;
    @(posedge core_clk);
    global_reset_n <= 1'b1;
    acc(0, 8'hE0, 32'h00000000);
    acc(0, 8'hF8, 32'h00000005);
    n = $urandom % 5 + 1;
    acc(1, 8'hDC, n);
    pulse(5'h10);
    burst <= 1'b1;
    c = 0;
    repeat (20) begin
      @(negedge core_clk);
      c += pri_grant_q;
    end
    @(posedge core_clk);
    burst <= 1'b0;
    cmp(c, n);
    acc(0, 8'hF4, n);
    acc(1, 8'hE0, 32'h00300000);
    wait_tx(13000);
    wait_tx(13000);
    cmp(c, 3072 * 4);
    acc(1, 8'hE4, 32'h00100000);
    wait_tx(13000);
    cmp(c, 13000);
    acc(0, 8'hF0, 32'h00000000);
    acc(1, 8'hE0, 32'h00500000);
    pulse(5'h08);
    wait_tx(8);
    cmp(c, 2);
    pulse(5'h04);
    cmp_evt(4'h0);
    acc(1, 8'hE4, 32'h00200000);
    pulse(5'h04);
    cmp_evt(4'h4);
    pulse(5'h02);
    cmp_evt(4'h0);
    acc(1, 8'hE0, 32'h00000400);
    pulse(5'h03);
    cmp_evt(4'h0);
    ar_req_ctx_enabled <= 1'b1;
    pulse(5'h02);
    cmp_evt(4'h2);
    acc(1, 8'hE0, 32'h00000200);
    pulse(5'h03);
    cmp_evt(4'h3);
    repeat (4) @(posedge core_clk);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
